/* File: hw/mbd_defines.vh */
/*
  Constants for the multiply and branch opcode decoder: register
  offsets, control fields, reset values, operation, word-count and
  condition encodings, and the opcode patterns that are matched.
  Assumes inclusion by bare name from the design file.
*/
`ifndef MBD_DEFINES_VH
`define MBD_DEFINES_VH

// ----------------------------------------
// Register map and fields
// ----------------------------------------
`define MBD_ADDR_CTRL 12'h000
`define MBD_ADDR_STATUS 12'h004
`define MBD_ADDR_WORDS 12'h008
`define MBD_ADDR_COUNT 12'h00c
`define MBD_CTRL_EN 0
`define MBD_CTRL_RESET 1'b1

// ----------------------------------------
// Full-word and partial-word patterns
// ----------------------------------------
`define MBD_W_ADDP 16'hce15
`define MBD_W_LDACCP 16'hce14
`define MBD_W_SUBP 16'hce16
`define MBD_W_SHIFT_HI 14'h3382
`define MBD_W_BRACC_HI 15'h6712
`define MBD_B_LDF 8'h3c
`define MBD_B_LDF_ACC 8'h3d
`define MBD_B_LDF_MOVE 8'h3f
`define MBD_B_LDF_PROD 8'h3e
`define MBD_B_LDF_SUB 8'h5b
`define MBD_B_LDPH 8'h53
`define MBD_B_MAC 8'h5d
`define MBD_B_MACMV 8'h5c
`define MBD_B_MPY 8'h38
`define MBD_B_MPYACC 8'h3a
`define MBD_B_MPYSUB 8'h3b
`define MBD_B_MULT_UNSIGNED_FORM 8'hcf
`define MBD_B_SQACC 8'h39
`define MBD_B_SQSUB 8'h5a
`define MBD_B_STPH 8'h7d
`define MBD_B_STPL 8'h7c
`define MBD_B_BR 8'hff
`define MBD_B_BRAUX 8'hfb
`define MBD_B_BRTCS 8'hf9
`define MBD_B_BRTCC 8'hf8
`define MBD_B_BRGEZ 8'hf4
`define MBD_B_BRGZ 8'hf1
`define MBD_B_BRLEZ 8'hf2
`define MBD_B_BRLZ 8'hf3
`define MBD_B_BRIO 8'hfa
`define MBD_B_BRNOV 8'hf7
`define MBD_B_BRC 8'h5e
`define MBD_B_BRNC 8'h5f
`define MBD_T_MULT_BY_IMMEDIATE 3'h5

// ----------------------------------------
// Decoded operation codes
// ----------------------------------------
`define MBD_OP_NONE 6'h00
`define MBD_OP_ADDP 6'h01
`define MBD_OP_LDACCP 6'h02
`define MBD_OP_SUBP 6'h03
`define MBD_OP_SHIFT 6'h04
`define MBD_OP_LDF 6'h05
`define MBD_OP_LDF_ACC 6'h06
`define MBD_OP_LDF_MOVE 6'h07
`define MBD_OP_LDF_PROD 6'h08
`define MBD_OP_LDF_SUB 6'h09
`define MBD_OP_LDPH 6'h0a
`define MBD_OP_MAC 6'h0b
`define MBD_OP_MACMV 6'h0c
`define MBD_OP_MPY 6'h0d
`define MBD_OP_MPYACC 6'h0e
`define MBD_OP_MPYSUB 6'h0f
`define MBD_OP_SQACC 6'h10
`define MBD_OP_SQSUB 6'h11
`define MBD_OP_STPH 6'h12
`define MBD_OP_STPL 6'h13
`define MBD_OP_MULT_BY_IMMEDIATE 6'h14
`define MBD_OP_MULT_UNSIGNED_FORM 6'h15
`define MBD_OP_BRANCH 6'h16
`define MBD_OP_BRACC 6'h17

// ----------------------------------------
// Word counts and branch conditions
// ----------------------------------------
`define MBD_ONE_WORD 2'h1
`define MBD_TWO_WORD 2'h2
`define MBD_CC_NONE 4'h0
`define MBD_CC_ALWAYS 4'h1
`define MBD_CC_AUXNZ 4'h2
`define MBD_CC_TCSET 4'h3
`define MBD_CC_TCCLR 4'h4
`define MBD_CC_CARRY 4'h5
`define MBD_CC_NOCARRY 4'h6
`define MBD_CC_GEZ 4'h7
`define MBD_CC_GZ 4'h8
`define MBD_CC_LEZ 4'h9
`define MBD_CC_LZ 4'ha
`define MBD_CC_IOLOW 4'hb
`define MBD_CC_NOV 4'hc

`endif

/* File: hw/mbd_decoder.v */
/*
  Multiply, product-register and branch opcode decoder with an APB
  register slave. Words arrive from program memory with a valid /
  ready handshake; one decoded result per instruction is presented.
  Assumes condition flags are stable when a branch's second word is
  accepted, and an APB master on the same clock.
*/
// Decided for this implementation: the APB interface to the registers and the placing of the registers.
// Operation
// - Word 0xCE15 decodes as add product to accumulator.
// - Word 0xCE14 decodes as load accumulator from product.
// - Word 0xCE16 decodes as subtract product from accumulator.
// - Words 0xCE08 to 0xCE0B set product shift; field in bits 1:0.
// - Byte 0x3C loads factor; 0x3D also accumulates; low byte is operand.
// - Byte 0x3F loads factor, accumulates and moves data.
// - Byte 0x3E loads factor and copies product to accumulator.
// - Byte 0x5B loads factor and subtracts previous product.
// - Byte 0x53 loads product high half from memory.
// - Bytes 0x5D and 0x5C are two-word multiply-accumulate forms.
// - Byte 0x38 multiplies factor by operand into product.
// - Byte 0x3A multiplies and accumulates; 0x3B multiplies and subtracts.
// - Byte 0x39 squares operand and accumulates.
// - Byte 0x5A squares operand and subtracts previous product.
// - Byte 0x7D stores product high; 0x7C stores product low.
// - Word 0xFF80 with bit 7 set is a two-word unconditional branch.
// - Bits 15:1 equal 0x6712 branch to the accumulator address.
// - Byte 0xFB branches when the auxiliary register is nonzero.
// - Byte 0xF9 branches on test flag set, 0xF8 on clear.
// - Bytes 0xF4, 0xF1, 0xF2, 0xF3 branch on accumulator sign tests.
// - Byte 0xFA branches when the I/O status input is low.
// - Byte 0xF7 branches when the overflow flag is clear.
`timescale 1ns/1ps
`include "mbd_defines.vh"
`default_nettype none

module mbd_decoder
(
  input wire mclk,
  input wire resetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire [15:0] fetchWord,
  input wire fetchValid,
  output reg fetchReady,
  input wire accZero,
  input wire accNegative,
  input wire carryFlag,
  input wire overflowFlag,
  input wire testControlFlag,
  input wire ioStatus,
  input wire auxNonzero,
  output reg opValid,
  output reg [5:0] opCode,
  output reg [1:0] wordCount,
  output reg [3:0] condCode,
  output reg [7:0] operandField,
  output reg [1:0] productShiftField,
  output reg [12:0] immField,
  output reg [15:0] extraWord,
  output reg branchTaken,
  output reg unknownOp
);

  localparam ST_FIRST = 2'b01;
  localparam ST_SECOND = 2'b10;

  reg [1:0] state;
  reg decodeEnable;
  reg [15:0] firstWord;
  reg [5:0] pendOp;
  reg [3:0] pendCond;
  reg [15:0] opCount;
  reg [15:0] unknownCount;
  reg [5:0] decOp;
  reg [3:0] decCond;
  reg decTwo;
  reg condMet;
  reg [31:0] readMux;
  reg addrHit;
  wire accept;
  wire emit;
  wire emitUnknown;
  wire apbAccess;
  wire apbCommit;
  wire ctrlWrite;
  wire countWrite;

  // ----------------------------------------
  // First-word decode
  // ----------------------------------------
  always @*
  begin
    // Whole and partial word patterns first, then the immediate form, then the byte table
    decOp = `MBD_OP_NONE;
    decCond = `MBD_CC_NONE;
    decTwo = 1'b0;
    if (fetchWord == `MBD_W_ADDP)
      decOp = `MBD_OP_ADDP;
    else if (fetchWord == `MBD_W_LDACCP)
      decOp = `MBD_OP_LDACCP;
    else if (fetchWord == `MBD_W_SUBP)
      decOp = `MBD_OP_SUBP;
    else if (fetchWord[15:2] == `MBD_W_SHIFT_HI)
      decOp = `MBD_OP_SHIFT;
    else if (fetchWord[15:1] == `MBD_W_BRACC_HI)
    begin
      decOp = `MBD_OP_BRACC;
      decCond = `MBD_CC_ALWAYS;
    end
    else if (fetchWord[15:13] == `MBD_T_MULT_BY_IMMEDIATE)
      decOp = `MBD_OP_MULT_BY_IMMEDIATE;
    else
    begin
      case (fetchWord[15:8])
        `MBD_B_LDF: decOp = `MBD_OP_LDF;
        `MBD_B_LDF_ACC: decOp = `MBD_OP_LDF_ACC;
        `MBD_B_LDF_MOVE: decOp = `MBD_OP_LDF_MOVE;
        `MBD_B_LDF_PROD: decOp = `MBD_OP_LDF_PROD;
        `MBD_B_LDF_SUB: decOp = `MBD_OP_LDF_SUB;
        `MBD_B_LDPH: decOp = `MBD_OP_LDPH;
        `MBD_B_MPY: decOp = `MBD_OP_MPY;
        `MBD_B_MPYACC: decOp = `MBD_OP_MPYACC;
        `MBD_B_MPYSUB: decOp = `MBD_OP_MPYSUB;
        `MBD_B_MULT_UNSIGNED_FORM: decOp = `MBD_OP_MULT_UNSIGNED_FORM;
        `MBD_B_SQACC: decOp = `MBD_OP_SQACC;
        `MBD_B_SQSUB: decOp = `MBD_OP_SQSUB;
        `MBD_B_STPH: decOp = `MBD_OP_STPH;
        `MBD_B_STPL: decOp = `MBD_OP_STPL;
        `MBD_B_MAC:
        begin
          decOp = `MBD_OP_MAC;
          decTwo = 1'b1;
        end
        `MBD_B_MACMV:
        begin
          decOp = `MBD_OP_MACMV;
          decTwo = 1'b1;
        end
        `MBD_B_BR:
        begin
          // Bit 7 clear under this byte is not a branch form
          if (fetchWord[7])
          begin
            decOp = `MBD_OP_BRANCH;
            decCond = `MBD_CC_ALWAYS;
            decTwo = 1'b1;
          end
        end
        `MBD_B_BRAUX: decCond = `MBD_CC_AUXNZ;
        `MBD_B_BRTCS: decCond = `MBD_CC_TCSET;
        `MBD_B_BRTCC: decCond = `MBD_CC_TCCLR;
        `MBD_B_BRGEZ: decCond = `MBD_CC_GEZ;
        `MBD_B_BRGZ: decCond = `MBD_CC_GZ;
        `MBD_B_BRLEZ: decCond = `MBD_CC_LEZ;
        `MBD_B_BRLZ: decCond = `MBD_CC_LZ;
        `MBD_B_BRIO: decCond = `MBD_CC_IOLOW;
        `MBD_B_BRNOV: decCond = `MBD_CC_NOV;
        `MBD_B_BRC: decCond = `MBD_CC_CARRY;
        `MBD_B_BRNC: decCond = `MBD_CC_NOCARRY;
        default: decOp = `MBD_OP_NONE;
      endcase
      // Conditional branch bytes share one operation code
      if (decCond != `MBD_CC_NONE)
      begin
        decOp = `MBD_OP_BRANCH;
        decTwo = 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Branch condition, sampled with the second word
  // ----------------------------------------
  always @*
  begin
    // Flags are read live; they must hold at the second word's edge
    case (pendCond)
      `MBD_CC_ALWAYS: condMet = 1'b1;
      `MBD_CC_AUXNZ: condMet = auxNonzero;
      `MBD_CC_TCSET: condMet = testControlFlag;
      `MBD_CC_TCCLR: condMet = ~testControlFlag;
      `MBD_CC_CARRY: condMet = carryFlag;
      `MBD_CC_NOCARRY: condMet = ~carryFlag;
      `MBD_CC_GEZ: condMet = ~accNegative;
      `MBD_CC_GZ: condMet = ~accNegative & ~accZero;
      `MBD_CC_LEZ: condMet = accNegative | accZero;
      `MBD_CC_LZ: condMet = accNegative;
      `MBD_CC_IOLOW: condMet = ~ioStatus;
      `MBD_CC_NOV: condMet = ~overflowFlag;
      default: condMet = 1'b0;
    endcase
  end

  // ----------------------------------------
  // Fetch sequencing and result registers
  // ----------------------------------------
  assign accept = fetchValid & fetchReady;
  assign emit = accept & ((state == ST_SECOND) | ~decTwo);
  // Unknown words still yield a one-word result
  assign emitUnknown = accept & (state == ST_FIRST) & (decOp == `MBD_OP_NONE);

  always @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      state <= ST_FIRST;
      fetchReady <= 1'b0;
      firstWord <= 16'h0000;
      pendOp <= `MBD_OP_NONE;
      pendCond <= `MBD_CC_NONE;
      opValid <= 1'b0;
      opCode <= `MBD_OP_NONE;
      wordCount <= `MBD_ONE_WORD;
      condCode <= `MBD_CC_NONE;
      operandField <= 8'h00;
      productShiftField <= 2'h0;
      immField <= 13'h0000;
      extraWord <= 16'h0000;
      branchTaken <= 1'b0;
      unknownOp <= 1'b0;
    end
    else
    begin
      // One word may still be taken in the cycle after disable
      fetchReady <= decodeEnable;
      opValid <= 1'b0;
      case (state)
        ST_FIRST:
        begin
          if (accept)
          begin
            firstWord <= fetchWord;
            // Decode is held until its data word arrives
            if (decTwo)
            begin
              pendOp <= decOp;
              pendCond <= decCond;
              state <= ST_SECOND;
            end
            else
            begin
              opValid <= 1'b1;
              opCode <= decOp;
              wordCount <= `MBD_ONE_WORD;
              condCode <= decCond;
              operandField <= fetchWord[7:0];
              branchTaken <= (decOp == `MBD_OP_BRACC);
              unknownOp <= (decOp == `MBD_OP_NONE);
              if (decOp == `MBD_OP_SHIFT)
                productShiftField <= fetchWord[1:0];
              if (decOp == `MBD_OP_MULT_BY_IMMEDIATE)
                immField <= fetchWord[12:0];
            end
          end
        end
        ST_SECOND:
        begin
          if (accept)
          begin
            opValid <= 1'b1;
            opCode <= pendOp;
            wordCount <= `MBD_TWO_WORD;
            condCode <= pendCond;
            operandField <= firstWord[7:0];
            // Second word is data, never decoded as an instruction
            extraWord <= fetchWord;
            branchTaken <= condMet;
            unknownOp <= 1'b0;
            state <= ST_FIRST;
          end
        end
        default: state <= ST_FIRST;
      endcase
    end
  end

  // ----------------------------------------
  // APB register access
  // ----------------------------------------
  assign apbAccess = psel & penable & ~pready;
  assign apbCommit = psel & penable & pready;

  // ----------------------------------------
  // Register write strobes
  // ----------------------------------------
  // Writes to STATUS and WORDS complete normally and change nothing
  assign ctrlWrite = apbCommit & pwrite & (paddr == `MBD_ADDR_CTRL);
  assign countWrite = apbCommit & pwrite & (paddr == `MBD_ADDR_COUNT);

  always @*
  begin
    addrHit = 1'b1;
    readMux = 32'h0000_0000;
    case (paddr)
      `MBD_ADDR_CTRL: readMux[`MBD_CTRL_EN] = decodeEnable;
      `MBD_ADDR_STATUS:
      begin
        // Field layout follows the result ports; gaps read as zero
        readMux[5:0] = opCode;
        readMux[9:8] = wordCount;
        readMux[11:10] = productShiftField;
        readMux[15:12] = condCode;
        readMux[16] = branchTaken;
        readMux[17] = unknownOp;
        readMux[18] = (state == ST_SECOND);
      end
      `MBD_ADDR_WORDS: readMux = {extraWord, firstWord};
      `MBD_ADDR_COUNT: readMux = {unknownCount, opCount};
      default: addrHit = 1'b0;
    endcase
  end

  always @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      decodeEnable <= `MBD_CTRL_RESET;
    end
    else
    begin
      // Registered answer keeps the bus outputs glitch free
      pready <= apbAccess;
      if (apbAccess)
      begin
        prdata <= pwrite ? 32'h0000_0000 : readMux;
        pslverr <= ~addrHit;
      end
      else
      begin
        // Answer stands for the pready cycle only
        prdata <= 32'h0000_0000;
        pslverr <= 1'b0;
      end
      if (ctrlWrite)
        decodeEnable <= pwdata[`MBD_CTRL_EN];
    end
  end

  // ----------------------------------------
  // Instruction counters, write clears
  // ----------------------------------------
  always @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      opCount <= 16'h0000;
      unknownCount <= 16'h0000;
    end
    else if (countWrite)
    begin
      // A count arriving with the clear is kept
      opCount <= emit ? 16'h0001 : 16'h0000;
      unknownCount <= emitUnknown ? 16'h0001 : 16'h0000;
    end
    else
    begin
      // Counts wrap at 16 bits; software must read often enough
      if (emit)
        opCount <= opCount + 16'h0001;
      if (emitUnknown)
        unknownCount <= unknownCount + 16'h0001;
    end
  end

endmodule

`default_nettype wire

/* File: sim/mbd_decoder_checker.sv */
/*
  Concurrent checks on the decoder's fetch side.
  Assumes binding to mbd_decoder and flags held while a branch completes.
*/
`timescale 1ns/1ps
`default_nettype none
`include "mbd_defines.vh"
module mbd_decoder_checker
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [15:0] fetchWord,
  input wire logic fetchValid,
  input wire logic fetchReady,
  input wire logic auxNonzero,
  input wire logic opValid,
  input wire logic [5:0] opCode,
  input wire logic [1:0] wordCount,
  input wire logic [1:0] productShiftField,
  input wire logic [12:0] immField,
  input wire logic [15:0] extraWord,
  input wire logic branchTaken
);
  // ----------------------------------------
  // Second-word tracking
  // ----------------------------------------
  wire logic take = fetchValid && fetchReady;
  wire logic [7:0] hi = fetchWord[15:8];
  wire logic isTwo = hi[7:2] == 6'h17 || (hi == 8'hff && fetchWord[7]) ||
    (hi >= 8'hf1 && hi <= 8'hfb && hi != 8'hf5 && hi != 8'hf6);
  logic pend;
  logic [7:0] firstHi;
  always @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      pend <= 1'b0;
      firstHi <= 8'h00;
    end
    else if (take)
    begin
      pend <= !pend && isTwo;
      firstHi <= pend ? firstHi : hi;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  chk_add_product: assert property (
    take && !pend && fetchWord == 16'hce15 |=> opValid && opCode == `MBD_OP_ADDP)
    else $error("add product word not decoded");
  chk_load_product: assert property (
    take && !pend && fetchWord == 16'hce14 |=> opValid && opCode == `MBD_OP_LDACCP)
    else $error("load from product word not decoded");
  chk_shift_field: assert property (
    take && !pend && fetchWord[15:2] == 14'h3382 |=> opCode == `MBD_OP_SHIFT &&
    productShiftField == $past(fetchWord[1:0]))
    else $error("shift field not taken");
  chk_imm_field: assert property (
    take && !pend && fetchWord[15:13] == 3'h5 |=> opCode == `MBD_OP_MULT_BY_IMMEDIATE &&
    immField == $past(fetchWord[12:0]))
    else $error("immediate multiply not decoded");
  chk_acc_branch: assert property (
    take && !pend && fetchWord[15:1] == 15'h6712 |=> opValid && branchTaken &&
    opCode == `MBD_OP_BRACC && wordCount == `MBD_ONE_WORD)
    else $error("accumulator branch not decoded");
  chk_first_waits: assert property (
    take && !pend && isTwo |=> !opValid)
    else $error("result given before second word");
  chk_dest_word: assert property (
    take && pend |=> opValid && wordCount == `MBD_TWO_WORD &&
    extraWord == $past(fetchWord))
    else $error("second word not carried");
  chk_aux_cond: assert property (
    take && pend && firstHi == 8'hfb |=> branchTaken == $past(auxNonzero))
    else $error("aux branch outcome wrong");
endmodule
bind mbd_decoder mbd_decoder_checker mbd_decoder_checker_inst
(
  .mclk, .resetn, .fetchWord, .fetchValid, .fetchReady, .auxNonzero, .opValid,
  .opCode, .wordCount, .productShiftField, .immField, .extraWord, .branchTaken
);
`default_nettype wire

/* File: sim/mbd_prog_mem.sv */
/*
  Program memory model feeding instruction words in order.
  Assumes words are loaded by task; stall slows the offer.
*/
`timescale 1ns/1ps
`default_nettype none
module mbd_prog_mem
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic stall,
  input wire logic fetchReady,
  output logic fetchValid,
  output logic [15:0] fetchWord
);
  logic [15:0] words[$];
  task automatic load(input logic [15:0] w);
    words.push_back(w);
  endtask
  // Word held until taken; idle bus toggles so stale data never passes
  always @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      fetchValid <= 1'b0;
      fetchWord <= 16'hffff;
    end
    else if (!fetchValid || fetchReady)
    begin
      if (!stall && words.size() > 0)
      begin
        fetchValid <= 1'b1;
        fetchWord <= words.pop_front();
      end
      else
      begin
        fetchValid <= 1'b0;
        fetchWord <= ~fetchWord;
      end
    end
  end
endmodule
`default_nettype wire

/* File: sim/tb_multiply_branch_opcode_decoder.sv */
/*
  Self-checking bench: every listed opcode under varied flags, random
  words with stalls, APB disable and error access.
  Assumes mbd_decoder and the program memory model.
*/
`timescale 1ns/1ps
`default_nettype none
`include "mbd_defines.vh"
module tb_multiply_branch_opcode_decoder;
  logic mclk, resetn, psel, penable, pwrite, pready, pslverr, stall, slow, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, seed, rd;
  logic fetchValid, fetchReady, opValid, branchTaken, unknownOp;
  logic accZero, accNegative, carryFlag, overflowFlag, testControlFlag, ioStatus, auxNonzero;
  logic [15:0] fetchWord, extraWord, mw, w;
  logic [5:0] opCode;
  logic [1:0] wordCount, productShiftField;
  logic [3:0] condCode;
  logic [7:0] operandField;
  logic [12:0] immField, md;
  logic [15:0] expq[$];
  logic [15:0] extq[$];
  int num_errors, num_checks, cycles;
  logic [15:0] corner[0:38] = '{16'hce15, 16'hce14, 16'hce16, 16'hce08, 16'hce0b,
    16'h3c12, 16'h3d34, 16'h3f56, 16'h3e78, 16'h5b9a, 16'h53bc, 16'h5dde, 16'h5cf0,
    16'h3801, 16'h3a23, 16'h3b45, 16'h3967, 16'h5a89, 16'h7dab, 16'h7ccd, 16'hff80,
    16'hce24, 16'hce25, 16'hfb11, 16'hf922, 16'hf833, 16'hf444, 16'hf155, 16'hf266,
    16'hf377, 16'hfa88, 16'hf799, 16'h5eaa, 16'h5fbb, 16'ha123, 16'hbfff, 16'hff00,
    16'hcf42, 16'h1234};
  mbd_decoder mbd_decoder_inst (.mclk, .resetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .fetchWord, .fetchValid, .fetchReady,
    .accZero, .accNegative, .carryFlag, .overflowFlag, .testControlFlag, .ioStatus,
    .auxNonzero, .opValid, .opCode, .wordCount, .condCode, .operandField,
    .productShiftField, .immField, .extraWord, .branchTaken, .unknownOp);
  mbd_prog_mem mbd_prog_mem_inst (.mclk, .resetn, .stall, .fetchReady, .fetchValid,
    .fetchWord);
  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  // ----------------------------------------
  // Expectation functions
  // ----------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  function automatic logic [12:0] one(input logic [5:0] op);
    return {1'b0, op, `MBD_ONE_WORD, `MBD_CC_NONE};
  endfunction
  function automatic logic [12:0] br(input logic [3:0] cc);
    return {1'b0, `MBD_OP_BRANCH, `MBD_TWO_WORD, cc};
  endfunction
  // Result is {unknown, opcode, word count, condition}
  function automatic logic [12:0] decode(input logic [15:0] v);
    if (v == 16'hce15) return one(`MBD_OP_ADDP);
    if (v == 16'hce14) return one(`MBD_OP_LDACCP);
    if (v == 16'hce16) return one(`MBD_OP_SUBP);
    if (v[15:2] == 14'h3382) return one(`MBD_OP_SHIFT);
    if (v[15:1] == 15'h6712) return one(`MBD_OP_BRACC);
    if (v[15:13] == 3'h5) return one(`MBD_OP_MULT_BY_IMMEDIATE);
    case (v[15:8])
      8'h3c: return one(`MBD_OP_LDF);
      8'h3d: return one(`MBD_OP_LDF_ACC);
      8'h3f: return one(`MBD_OP_LDF_MOVE);
      8'h3e: return one(`MBD_OP_LDF_PROD);
      8'h5b: return one(`MBD_OP_LDF_SUB);
      8'h53: return one(`MBD_OP_LDPH);
      8'h5d: return {1'b0, `MBD_OP_MAC, `MBD_TWO_WORD, `MBD_CC_NONE};
      8'h5c: return {1'b0, `MBD_OP_MACMV, `MBD_TWO_WORD, `MBD_CC_NONE};
      8'h38: return one(`MBD_OP_MPY);
      8'h3a: return one(`MBD_OP_MPYACC);
      8'h3b: return one(`MBD_OP_MPYSUB);
      8'h39: return one(`MBD_OP_SQACC);
      8'h5a: return one(`MBD_OP_SQSUB);
      8'h7d: return one(`MBD_OP_STPH);
      8'h7c: return one(`MBD_OP_STPL);
      8'hcf: return one(`MBD_OP_MULT_UNSIGNED_FORM);
      8'hff: return v[7] ? br(`MBD_CC_ALWAYS) : {1'b1, 12'h010};
      8'hfb: return br(`MBD_CC_AUXNZ);
      8'hf9: return br(`MBD_CC_TCSET);
      8'hf8: return br(`MBD_CC_TCCLR);
      8'hf4: return br(`MBD_CC_GEZ);
      8'hf1: return br(`MBD_CC_GZ);
      8'hf2: return br(`MBD_CC_LEZ);
      8'hf3: return br(`MBD_CC_LZ);
      8'hfa: return br(`MBD_CC_IOLOW);
      8'hf7: return br(`MBD_CC_NOV);
      8'h5e: return br(`MBD_CC_CARRY);
      8'h5f: return br(`MBD_CC_NOCARRY);
      default: return {1'b1, 12'h010};
    endcase
  endfunction
  function automatic logic taken(input logic [3:0] cc);
    case (cc)
      `MBD_CC_AUXNZ: return auxNonzero;
      `MBD_CC_TCSET: return testControlFlag;
      `MBD_CC_TCCLR: return !testControlFlag;
      `MBD_CC_GEZ: return !accNegative;
      `MBD_CC_GZ: return !accNegative && !accZero;
      `MBD_CC_LEZ: return accNegative || accZero;
      `MBD_CC_LZ: return accNegative;
      `MBD_CC_IOLOW: return !ioStatus;
      `MBD_CC_NOV: return !overflowFlag;
      `MBD_CC_CARRY: return carryFlag;
      `MBD_CC_NOCARRY: return !carryFlag;
      default: return 1'b1;
    endcase
  endfunction
  // ----------------------------------------
  // Drivers and checks
  // ----------------------------------------
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    num_checks++;
    if (s !== e)
    begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic send(input logic [15:0] v);
    expq.push_back(v);
    mbd_prog_mem_inst.load(v);
    if ((decode(v) & 13'h0030) == 13'h0020)
    begin
      seed = xs(seed);
      extq.push_back(seed[15:0]);
      mbd_prog_mem_inst.load(seed[15:0]);
    end
  endtask
  task automatic drain();
    for (int i = 0; i < 400 && expq.size() > 0; i++)
      @(posedge mclk);
    chk("pending words", 0, expq.size());
  endtask
  task automatic new_flags();
    seed = xs(seed);
    {accZero, accNegative, carryFlag, overflowFlag, testControlFlag, ioStatus,
      auxNonzero} <= seed[6:0];
  endtask
  always @(posedge mclk)
  begin
    cycles++;
    stall <= slow && rd[cycles % 32];
    if (cycles == 30000)
    begin
      num_errors++;
      give_verdict();
    end
    if (resetn && opValid === 1'b1)
    begin
      mw = expq.pop_front();
      md = decode(mw);
      if (md[5:4] == `MBD_ONE_WORD)
        chk("unknownOp", md[12], unknownOp);
      if (!md[12])
      begin
        chk("opCode", md[11:6], opCode);
        chk("wordCount", md[5:4], wordCount);
        chk("operandField", mw[7:0], operandField);
        if (md[11:6] != `MBD_OP_BRACC)
          chk("condCode", md[3:0], condCode);
        if (md[11:6] == `MBD_OP_BRANCH)
          chk("branchTaken", taken(md[3:0]), branchTaken);
        if (md[5:4] == `MBD_TWO_WORD)
          chk("extraWord", extq.pop_front(), extraWord);
      end
    end
  end
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, stall, slow, resetn, cycles} = '0;
    {accZero, accNegative, carryFlag, overflowFlag, testControlFlag, ioStatus} = '0;
    auxNonzero = 1'b0;
    seed = 32'h7aea;
    rd = 32'h0;
    repeat (3) @(posedge mclk);
    resetn <= 1'b1;
    for (int k = 0; k < 8; k++)
    begin
      new_flags();
      foreach (corner[i])
        send(corner[i]);
      drain();
    end
    slow = 1'b1;
    rd = 32'h5a3c96e1;
    for (int k = 0; k < 20; k++)
    begin
      new_flags();
      for (int j = 0; j < 10; j++)
      begin
        seed = xs(seed);
        w = corner[seed % 39];
        if (w[15:8] != 8'hce)
          w[7:0] = seed[15:8];
        send(w);
      end
      drain();
    end
    apb(1'b1, `MBD_ADDR_CTRL, 32'h0);
    apb(1'b0, `MBD_ADDR_CTRL, 32'h0);
    chk("ctrl readback", 32'h0, rd);
    send(16'hce15);
    repeat (10) @(posedge mclk);
    chk("fetch while off", 1, expq.size());
    apb(1'b1, `MBD_ADDR_CTRL, 32'h1);
    drain();
    apb(1'b0, 12'h010, 32'h0);
    chk("unmapped error", 1'b1, err);
    apb(1'b0, `MBD_ADDR_STATUS, 32'h0);
    chk("status opcode", `MBD_OP_ADDP, rd[5:0]);
    give_verdict();
  end
endmodule
`default_nettype wire
